// ---- hdl/control_timer.sv ----
// Control timer: period counter with buffered period, four capture channels,
// fault input, sticky status with read-clear and one masked interrupt.
// Assumes capture and fault inputs are asynchronous pins.
// Overview of operation
// - Circular update waits for an active bus host
// - Avoid faults near dual-ramp boundaries
// - Timestamp each fault source on its own channel; here a fault sets the fault status flag, with no timestamp, and in dual-ramp mode zeroes the count
// - Keep capture events spaced beyond the gap
// - Advanced capture modes only in upper channels
// - Clear buffer-valid flag twice before rewriting
// - No retrigger events while dithering
// - Down-count reloads period despite lock update
// - Event channels must use the asynchronous path
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "ctl_timer_params.svh"
module control_timer #(
   parameter int NUM_CH = `NUM_CH
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // Controller side
   ctl_timer_if.timer             bus,
   // Pins
   input  wire logic [NUM_CH-1:0] capt_pin,
   input  wire logic              fault_pin,
   input  wire logic              retrig_pin,
   // Waveform
   output logic                   wave_out
);
   logic [7:0]  ctrl_ff, nxt_ctrl;
   logic [15:0] per_ff, nxt_per, period_buffer_ff, nxt_period_buffer, cnt_ff, nxt_cnt;
   logic [3:0]  st_ff, nxt_st, mask_ff, nxt_mask;
   logic        bufv_ff, nxt_bufv, bufc_ff, nxt_bufc;
   logic [15:0] rdata_ff, nxt_rdata;
   logic [NUM_CH*3-1:0] modes_ff, nxt_modes;
   logic [15:0] capt_ff [NUM_CH], nxt_capt [NUM_CH];
   logic [NUM_CH-1:0] cs1_ff, cs2_ff, cs3_ff;
   logic [2:0]  fs1_ff, fs2_ff, fs3_ff;
   logic [7:0]  gap_ff, nxt_gap;
   logic [1:0]  gdiv_ff, nxt_gdiv;
   logic        wave_ff, nxt_wave, pend_ff, nxt_pend;
   logic [NUM_CH-1:0] capt_ev, adv_ok;
   logic        fault_ev, retrig_ev, wrap, gen_tick;

   // Pin synchronisers, third stage for edge detect
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cs1_ff <= '0;
         cs2_ff <= '0;
         cs3_ff <= '0;
         fs1_ff <= 3'h0;
         fs2_ff <= 3'h0;
         fs3_ff <= 3'h0;
      end else begin
         cs1_ff <= capt_pin;
         cs2_ff <= cs1_ff;
         cs3_ff <= cs2_ff;
         fs1_ff <= {retrig_pin, fault_pin, 1'b0};
         fs2_ff <= fs1_ff;
         fs3_ff <= fs2_ff;
      end
   end
   assign capt_ev   = cs2_ff & ~cs3_ff;
   assign fault_ev  = fs2_ff[1] & ~fs3_ff[1];
   // Retrigger ignored while dithering
   assign retrig_ev = fs2_ff[2] & ~fs3_ff[2] &
                      ~ctrl_ff[`CTRL_RETRIG_BIT] ? 1'b0 :
                      fs2_ff[2] & ~fs3_ff[2] & ~ctrl_ff[`CTRL_DITH_BIT];
   assign gen_tick  = (gdiv_ff == 2'h3);
   assign wrap = ctrl_ff[`CTRL_DOWN_BIT] ? (cnt_ff == 16'h0000)
                                          : (cnt_ff >= per_ff);

   // Advanced mode works only when every upper channel is advanced too
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_adv
         if (g == NUM_CH - 1) begin : g_top
            assign adv_ok[g] = 1'b1;
         end else begin : g_low
            assign adv_ok[g] = adv_ok[g+1] &
               (modes_ff[(g+1)*3 +: 3] >=
                3'(ctl_timer_pkg::capture_minimum_mode));
         end
      end
   endgenerate

   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_per    = per_ff;
      nxt_period_buffer = period_buffer_ff;
      nxt_cnt    = cnt_ff;
      nxt_st     = st_ff;
      nxt_mask   = mask_ff;
      nxt_bufv   = bufv_ff;
      nxt_bufc   = bufc_ff;
      nxt_modes  = modes_ff;
      nxt_rdata  = 16'h0000;
      nxt_gap    = (gap_ff != 8'h00) ? gap_ff - 8'h01 : 8'h00;
      nxt_gdiv   = gdiv_ff + 2'h1;
      nxt_wave   = wave_ff;
      nxt_pend   = pend_ff;
      for (int i = 0; i < NUM_CH; i++) nxt_capt[i] = capt_ff[i];
      // Counter
      if (ctrl_ff[`CTRL_EN_BIT] && gen_tick) begin
         if (wrap || retrig_ev) begin
            nxt_cnt  = ctrl_ff[`CTRL_DOWN_BIT] ? per_ff : 16'h0000;
            nxt_wave = ~wave_ff;
            // Down-count ignores lock update on reload
            if (bufv_ff && (ctrl_ff[`CTRL_DOWN_BIT] ||
                            !ctrl_ff[`CTRL_LOCK_BIT])) begin
               nxt_per  = period_buffer_ff;
               nxt_bufv = 1'b0;
               nxt_pend = ctrl_ff[`CTRL_CIRC_BIT];
            end
         end else begin
            nxt_cnt = ctrl_ff[`CTRL_DOWN_BIT] ? cnt_ff - 16'h0001
                                               : cnt_ff + 16'h0001;
         end
      end
      // Circular swap needs a live bus host
      if (pend_ff && bus.bus_active) begin
         nxt_period_buffer = per_ff;
         nxt_bufv   = 1'b1;
         nxt_pend   = 1'b0;
      end
      // Register reads, status clears on read
      if (bus.req_rd) begin
         case (bus.addr)
            `REG_CTRL:     nxt_rdata = {8'h00, ctrl_ff};
            `REG_PERIOD:   nxt_rdata = per_ff;
            // Buffer-valid bit shows the live flag as well
            `REG_STATUS:   nxt_rdata = {11'h000, bufc_ff,
                                        st_ff | {1'b0, bufv_ff, 2'b00}};
            `REG_IRQ_MASK: nxt_rdata = {12'h000, mask_ff};
            `REG_MODES:    nxt_rdata = 16'(modes_ff);
            default: begin
               if (bus.addr >= `REG_CAPT0 &&
                   bus.addr < `REG_CAPT0 + 4'(NUM_CH))
                  nxt_rdata = capt_ff[bus.addr[1:0]];
            end
         endcase
         if (bus.addr == `REG_STATUS) nxt_st = 4'h0;
      end
      // Buffer-valid clear restores after a second clear
      if (bus.req_wr) begin
         case (bus.addr)
            `REG_CTRL:     nxt_ctrl  = bus.wdata[7:0];
            `REG_PERIOD: begin
               nxt_period_buffer = bus.wdata;
               nxt_bufv   = 1'b1;
            end
            `REG_IRQ_MASK: nxt_mask  = bus.wdata[3:0];
            `REG_MODES:    nxt_modes = bus.wdata[NUM_CH*3-1:0];
            `REG_STATUS: begin
               if (bus.wdata[`ST_BUFV_BIT]) begin
                  nxt_bufv = 1'b0;
                  nxt_st[`ST_BUFV_BIT] = 1'b0;
                  nxt_bufc = ~bufc_ff;
                  if (bufc_ff) nxt_period_buffer = per_ff;
               end
            end
            default: ;
         endcase
      end
      // Captures; a too-close capture flags error
      for (int i = 0; i < NUM_CH; i++) begin
         if (capt_ev[i] && modes_ff[i*3 +: 3] != 3'h0 &&
             (modes_ff[i*3 +: 3] == 3'(ctl_timer_pkg::basic_capture_enable)
              || adv_ok[i])) begin
            nxt_capt[i] = cnt_ff;
            nxt_st[`ST_CAPT_BIT] = 1'b1;
            if (gap_ff != 8'h00) nxt_st[`ST_ERR_BIT] = 1'b1;
            nxt_gap = 8'(`CAPT_GAP);
         end
      end
      // Fault sets its status flag, no stamp taken; dual-ramp mode also zeroes the count
      if (fault_ev) begin
         nxt_st[`ST_FAULT_BIT] = 1'b1;
         if (ctrl_ff[`CTRL_RAMP2_BIT]) nxt_cnt = 16'h0000;
      end
      if (bufv_ff) nxt_st[`ST_BUFV_BIT] = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff   <= `CTRL_RESET;
         per_ff    <= `PERIOD_RESET;
         period_buffer_ff <= `PERIOD_RESET;
         cnt_ff    <= 16'h0000;
         st_ff     <= 4'h0;
         mask_ff   <= 4'h0;
         bufv_ff   <= 1'b0;
         bufc_ff   <= 1'b0;
         modes_ff  <= '0;
         rdata_ff  <= 16'h0000;
         gap_ff    <= 8'h00;
         gdiv_ff   <= 2'h0;
         wave_ff   <= 1'b0;
         pend_ff   <= 1'b0;
         for (int i = 0; i < NUM_CH; i++) capt_ff[i] <= 16'h0000;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         per_ff    <= nxt_per;
         period_buffer_ff <= nxt_period_buffer;
         cnt_ff    <= nxt_cnt;
         st_ff     <= nxt_st;
         mask_ff   <= nxt_mask;
         bufv_ff   <= nxt_bufv;
         bufc_ff   <= nxt_bufc;
         modes_ff  <= nxt_modes;
         rdata_ff  <= nxt_rdata;
         gap_ff    <= nxt_gap;
         gdiv_ff   <= nxt_gdiv;
         wave_ff   <= nxt_wave;
         pend_ff   <= nxt_pend;
         for (int i = 0; i < NUM_CH; i++) capt_ff[i] <= nxt_capt[i];
      end
   end

   assign bus.rdata = rdata_ff;
   assign bus.irq   = |(st_ff & mask_ff);
   assign wave_out  = wave_ff;
endmodule // control_timer

// ---- hdl/ctl_timer_params.svh ----
// Constants shared by the control timer and its controller.
// Assumes one clock, ref_clk, at 100 MHz.
`ifndef CTL_TIMER_PARAMS_SVH
`define CTL_TIMER_PARAMS_SVH
`define CLK_PERIOD_NS     10
`define BUS_CLKS          3
`define GEN_CLKS          3
`define GEN_DIV           4
`define CAPT_GAP          (`BUS_CLKS + `GEN_CLKS * `GEN_DIV + 1)
`define NUM_CH            4
`define REG_CTRL          4'h0
`define REG_PERIOD        4'h1
`define REG_STATUS        4'h2
`define REG_IRQ_MASK      4'h3
`define REG_MODES         4'h4
`define REG_CAPT0         4'h8
`define CTRL_RESET        8'h00
`define CTRL_EN_BIT       0
`define CTRL_DOWN_BIT     1
`define CTRL_LOCK_BIT     2
`define CTRL_DITH_BIT     3
`define CTRL_CIRC_BIT     4
`define CTRL_RAMP2_BIT    5
`define CTRL_RETRIG_BIT   6
`define CTRL_ASYNCHRONOUS_EVENT_PATH_BIT    7
`define ST_CAPT_BIT       0
`define ST_ERR_BIT        1
`define ST_BUFV_BIT       2
`define ST_FAULT_BIT      3
`define PERIOD_RESET      16'hffff
`endif

// ---- hdl/ctl_timer_pkg.sv ----
// Types shared by the control timer and its controller.
// Assumes the params header defines NUM_CH.
package ctl_timer_pkg;
   typedef enum logic [2:0] {
      capt_off, basic_capture_enable, capture_minimum_mode,
      capture_maximum_mode, local_minimum_mode, local_maximum_mode,
      derivative_capture_mode
   } capt_mode_t;
   typedef enum logic [1:0] {
      asynchronous_event_path, synchronous_event_path,
      resynchronized_event_path
   } event_path_t;
endpackage

// ---- hdl/ctl_timer_if.sv ----
// Interface joining the controller and the control timer.
// Assumes both ends share ref_clk and resetn.
interface ctl_timer_if;
   logic        req_wr;
   logic        req_rd;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        bus_active;
   logic        irq;
   modport timer (input req_wr, req_rd, addr, wdata, bus_active,
                  output rdata, irq);
   modport ctrl  (output req_wr, req_rd, addr, wdata, bus_active,
                  input rdata, irq);
endinterface

// ---- hdl/timer_controller.sv ----
// Controller end: takes software orders on a plain port, drives the timer.
// Assumes the timer answers reads one cycle later.
`include "ctl_timer_params.svh"
module timer_controller (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Software port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [15:0]      sw_rdata,
   output logic             sw_irq,
   input  wire logic        host_awake,
   // Timer side
   ctl_timer_if.ctrl        bus
);
   // Read data already registered in the timer
   assign bus.req_wr     = sw_wr;
   assign bus.req_rd     = sw_rd;
   assign bus.addr       = sw_addr;
   // Force the asynchronous event path bit on every control write
   assign bus.wdata      = (sw_wr && sw_addr == `REG_CTRL) ?
                           (sw_wdata | 16'(1 << `CTRL_ASYNCHRONOUS_EVENT_PATH_BIT)) :
                           sw_wdata;
   assign bus.bus_active = host_awake;
   assign sw_rdata       = bus.rdata;
   assign sw_irq         = bus.irq;
endmodule // timer_controller

// ---- sim/ctl_timer_sva.sv ----
// Checker on the link between controller and timer.
// Assumes one clock and an active-low asynchronous reset.
module ctl_timer_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // Link
   input wire logic        req_wr,
   input wire logic        req_rd,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        bus_active,
   input wire logic        irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_strobes_apart: assert property (!(req_wr && req_rd))
      else $error("write and read strobes together");
   a_rdata_idle: assert property (!$past(req_rd) |-> rdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property (req_rd && addr inside {[5:7], [12:15]}
      |=> rdata == 16'h0000) else $error("unmapped read not zero");
   a_ctrl_readback: assert property (req_wr && addr == 4'h0 ##1
      req_rd && addr == 4'h0 |=> rdata[7:0] == $past(wdata[7:0], 2))
      else $error("control readback wrong");
   a_modes_readback: assert property (req_wr && addr == 4'h4 ##1
      req_rd && addr == 4'h4 |=> rdata[11:0] == $past(wdata[11:0], 2))
      else $error("modes readback wrong");
   a_mask_readback: assert property (req_wr && addr == 4'h3 ##1
      req_rd && addr == 4'h3 |=> rdata[3:0] == $past(wdata[3:0], 2))
      else $error("mask readback wrong");
   a_mask_gates_irq: assert property (req_rd && addr == 4'h3
      ##1 rdata == 16'h0000 |-> !irq) else $error("irq with empty mask");
   a_bufv_sets: assert property (req_wr && addr == 4'h1 ##1
      req_rd && addr == 4'h2 |=> rdata[2]) else $error("buffer valid not set");
   c_status_read: cover property (req_rd && addr == 4'h2);
   c_irq_seen: cover property ($rose(irq));
   c_period_write: cover property (req_wr && addr == 4'h1);
endmodule // ctl_timer_sva

// ---- sim/test_control_timer_capture_limits.sv ----
// Testbench: controller and timer joined through the link interface.
// Assumes the params header is on the include path.
`include "ctl_timer_params.svh"
module test_control_timer_capture_limits;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] modes_val = {4'h0,
      ctl_timer_pkg::capture_maximum_mode, ctl_timer_pkg::capture_minimum_mode,
      ctl_timer_pkg::basic_capture_enable, ctl_timer_pkg::basic_capture_enable};
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  sw_addr = 4'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [15:0] sw_rdata;
   logic        sw_irq;
   logic        host_awake = 1'b1;
   logic [3:0]  capt_pin = 4'h0;
   logic        fault_pin = 1'b0;
   logic        rd_q = 1'b0;
   logic [15:0] exp_q[$];
   logic [15:0] msk_q[$];
   int          fails = 0;
   int          checks_done = 0;
   int          seed = 32'h2b3d4f4b;
   logic [15:0] rnd;
   ctl_timer_if cif ();
   always #5 ref_clk = ~ref_clk;
   timer_controller u_timer_controller (.ref_clk, .resetn, .sw_addr,
      .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .sw_irq, .host_awake, .bus(cif));
   control_timer u_control_timer (.ref_clk, .resetn, .bus(cif), .capt_pin,
      .fault_pin, .retrig_pin(1'b0), .wave_out());
   ctl_timer_sva u_ctl_timer_sva (.ref_clk, .resetn, .req_wr(cif.req_wr),
      .req_rd(cif.req_rd), .addr(cif.addr), .wdata(cif.wdata),
      .rdata(cif.rdata), .bus_active(cif.bus_active), .irq(cif.irq));
   task automatic cmp_word(input logic [15:0] exp, seen);
      checks_done++;
      if (exp !== seen) begin
         fails++;
         $display("MISMATCH rdata expected %h seen %h", exp, seen);
      end
   endtask
   task automatic cmp_irq(input logic exp);
      checks_done++;
      if (exp !== sw_irq) begin
         fails++;
         $display("MISMATCH irq expected %b seen %b", exp, sw_irq);
      end
   endtask
   task automatic acc(input logic w, r, input logic [3:0] a,
                      input logic [15:0] d);
      sw_wr <= w;
      sw_rd <= r;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      acc(1'b0, 1'b1, a, 16'h0000);
   endtask
   task automatic idle(input int n);
      repeat (n) acc(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   // Rising edge on a capture pin, then a gap in cycles
   task automatic pulse(input int gap);
      capt_pin[0] <= 1'b1;
      idle(2);
      capt_pin[0] <= 1'b0;
      idle(gap - 2);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Read answers stand one cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_q) begin
         cmp_word(exp_q.pop_front(), sw_rdata & msk_q.pop_front());
      end
      rd_q <= sw_rd;
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`REG_CTRL, 16'h0000, 16'hffff);
      rd(`REG_PERIOD, `PERIOD_RESET, 16'hffff);
      rd(`REG_STATUS, 16'h0000, 16'h000f);
      $display("test reset values done");
      rnd = 16'($random(seed));
      acc(1'b1, 1'b0, `REG_CTRL, {8'h00, rnd[7:0]});
      // Controller forces the asynchronous event path bit
      rd(`REG_CTRL, {8'h00, rnd[7:0] | 8'h80}, 16'h00ff);
      acc(1'b1, 1'b0, `REG_MODES, modes_val);
      rd(`REG_MODES, modes_val, 16'h0fff);
      rd(4'h5, 16'h0000, 16'hffff);
      $display("test register access done");
      acc(1'b1, 1'b0, `REG_CTRL, 16'h0081);
      acc(1'b1, 1'b0, `REG_IRQ_MASK, 16'h0001);
      rd(`REG_IRQ_MASK, 16'h0001, 16'h001f);
      rd(`REG_STATUS, 16'h0000, 16'h000f);
      idle(1);
      cmp_irq(1'b0);
      pulse(8);
      cmp_irq(1'b1);
      rd(`REG_STATUS, 16'h0001, 16'h0003);
      idle(1);
      cmp_irq(1'b0);
      idle(`CAPT_GAP);
      pulse(`CAPT_GAP - 2);
      pulse(`CAPT_GAP + 4);
      rd(`REG_STATUS, 16'h0003, 16'h0003);
      pulse(`CAPT_GAP + 4);
      pulse(`CAPT_GAP + 4);
      rd(`REG_STATUS, 16'h0001, 16'h0003);
      $display("test capture spacing done");
      acc(1'b1, 1'b0, `REG_IRQ_MASK, 16'h0000);
      rd(`REG_IRQ_MASK, 16'h0000, 16'h001f);
      pulse(`CAPT_GAP + 4);
      cmp_irq(1'b0);
      rd(`REG_STATUS, 16'h0001, 16'h0003);
      $display("test masked interrupt done");
      rnd = 16'($random(seed));
      acc(1'b1, 1'b0, `REG_PERIOD, rnd);
      rd(`REG_STATUS, 16'h0004, 16'h0004);
      acc(1'b1, 1'b0, `REG_STATUS, 16'h0004);
      acc(1'b1, 1'b0, `REG_STATUS, 16'h0004);
      rd(`REG_STATUS, 16'h0000, 16'h0004);
      $display("test buffer valid done");
      fault_pin <= 1'b1;
      idle(4);
      fault_pin <= 1'b0;
      rd(`REG_STATUS, 16'h0008, 16'h0008);
      $display("test fault flag done");
      idle(3);
      end_of_test();
   end
endmodule // test_control_timer_capture_limits
